// [inc/afcsp_pkg.sv]
// Purpose: shared constants and types of the filter configuration serial port
// Assumes: one system clock; serial pins arrive asynchronously
// Notes:   configuration word layout, codes, presets and frame sizes
package afcsp_pkg;

  // ---------------------------------------------------------------
  // control word layout
  // ---------------------------------------------------------------
  localparam int          CW_BITS   = 12;
  localparam int          CFG_W     = 10;
  localparam int          FT_LSB    = 0;
  localparam int          DF_LSB    = 4;
  localparam int          CODE_W    = 4;
  localparam int          GE_BIT    = 8;
  localparam int          GC_BIT    = 9;
  localparam logic [1:0]  PFX_VALID = 2'h2;
  localparam logic [3:0]  BIT_LAST  = 4'hB;
  localparam logic [3:0]  BIT_PFX   = 4'h1;

  // ---------------------------------------------------------------
  // codes and presets
  // ---------------------------------------------------------------
  localparam logic [3:0]  FT_MIN    = 4'h1;
  localparam logic [3:0]  FT_AVG    = 4'h7;
  localparam logic [3:0]  DF_MIN    = 4'h2;
  localparam logic [3:0]  DF_MAX    = 4'hE;
  // ssinc, factor 64, gains off
  localparam logic [9:0]  CFG_PRESET_SSINC = 10'h065;
  // averaging, gains off; factor field unused in averaging
  localparam logic [9:0]  CFG_PRESET_AVG   = 10'h027;
  localparam logic [9:0]  CFG_RESET        = 10'h065;

  // ---------------------------------------------------------------
  // data frames and counters
  // ---------------------------------------------------------------
  localparam int          RESULT_W  = 32;
  localparam int          FRAME_W   = 40;
  localparam int          DIRECT_W  = 32;
  localparam logic [5:0]  DIRECT_BITS = 6'h20;
  localparam int          CNT_W     = 15;
  localparam logic [14:0] CNT_ONE   = 15'h0001;

  // ---------------------------------------------------------------
  // pin synchroniser slots
  // ---------------------------------------------------------------
  localparam int          NPIN      = 6;
  localparam int          PIN_ACLK  = 0;
  localparam int          PIN_BCLK  = 1;
  localparam int          PIN_RDA   = 2;
  localparam int          PIN_RDB   = 3;
  localparam int          PIN_SDI   = 4;
  localparam int          PIN_PRE   = 5;
  localparam logic [5:0]  PIN_RST   = 6'h0C;

  typedef enum logic {CFG_CLOSED, CFG_OPEN} afcsp_win_t;

endpackage : afcsp_pkg

// [src/afcsp_sync.sv]
// Purpose: three-flop pin synchroniser with edge pulses
// Assumes: async_i is from outside the clock domain
// Notes:   a change counts once the second and third flops agree
`timescale 1ns/1ps
module afcsp_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic async_i,
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end
    else
    begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      lvl_q <= RST_VAL;
    else if (s2_q == s3_q)
      lvl_q <= s3_q;
  end

  assign level_o = lvl_q;
  assign rise_o  = (s2_q == s3_q) && s3_q && !lvl_q;
  assign fall_o  = (s2_q == s3_q) && !s3_q && lvl_q;

endmodule : afcsp_sync

// [src/afcsp_buf2.sv]
// Purpose: small valid/ready buffer for the no-latency words
// Assumes: both sides on clk_i
// Notes:   full drops in_ready_o so the source stalls instead of losing words
`timescale 1ns/1ps
module afcsp_buf2 #(
  parameter int W     = 32,
  parameter int DEPTH = 2
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  logic          push;
  logic          pop;

  assign in_ready_o  = (cnt_q != CW'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem_q[rd_q];

  always_ff @(posedge clk_i)
  begin
    if (push)
      mem_q[wr_q] <= in_data_i;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : PW'(wr_q + 1'b1);
      if (pop)
        rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : PW'(rd_q + 1'b1);
      if (push && !pop)
        cnt_q <= CW'(cnt_q + 1'b1);
      else if (pop && !push)
        cnt_q <= CW'(cnt_q - 1'b1);
    end
  end

endmodule : afcsp_buf2

// [src/afcsp_serial_port.sv]
// Purpose: configuration and readout logic of the oversampling converter ports
// Assumes: conversion start/done pulses and results come from core logic on clk_i
// Notes:   serial clocks are sampled, so they must be well below clk_i / 6
//
// How it works
// - port A drives only while its read enable is low; port B likewise.
// - output bits advance on rising port clock edges, each port its own clock.
// - configuration input is sampled on rising port A clock edges.
// - twelve-bit control word arrives most significant bit first, one per edge.
// - bits 3..0 filter, 7..4 factor, 8 gain expand, 9 gain compress.
// - filter codes 1..7 are valid types; any other code is invalid.
// - factor codes 2..14 give 4 up to 16384 doubling; others invalid.
// - window opens at reset, data-ready fall, port A enable fall, or sync.
// - opening window resets the state machine and expects twelve clock pulses.
// - window closes when data-ready rises or after the twelfth pulse.
// - word valid only with top bits 10 and all bits inside the window.
// - valid word resets filter if changed, takes effect next conversion.
// - partial words dropped; bad prefix closes the window at once.
// - all-zero word leaves the configuration untouched.
// - preset pin high: ignore serial, input level picks averaging or ssinc 64.
// - result updates every factor conversions, each conversion when averaging; data-ready spans that conversion.
// - whole 32-bit result readable between update and following conversion.
// - one result may be read across many conversions at slow clock.
// - an 8-bit field with factor and type follows the result, 40 bits total.
`timescale 1ns/1ps
module afcsp_serial_port
  import afcsp_pkg::*;
(
  input  wire logic                          clk_i,
  input  wire logic                          rstn_i,
  input  wire logic                          filtered_port_clk_i,
  input  wire logic                          direct_port_clk_i,
  input  wire logic                          filtered_port_read_en_n_i,
  input  wire logic                          direct_port_read_en_n_i,
  input  wire logic                          config_serial_in_i,
  input  wire logic                          preset_sel_i,
  input  wire logic                          conv_start_i,
  input  wire logic                          conv_done_i,
  input  wire logic                          sync_reset_i,
  input  wire logic [afcsp_pkg::RESULT_W-1:0] filtered_result_i,
  input  wire logic [afcsp_pkg::DIRECT_W-1:0] direct_word_i,
  input  wire logic                          direct_valid_i,
  output logic                               direct_ready_o,
  output logic                               filtered_serial_out_o,
  output logic                               filtered_serial_oe_n_o,
  output logic                               direct_serial_out_o,
  output logic                               direct_serial_oe_n_o,
  output logic                               filtered_data_ready_o,
  output logic                               filter_reset_o,
  output logic [3:0]                         filter_type_o,
  output logic [3:0]                         downsample_factor_o,
  output logic                               gain_expand_en_o,
  output logic                               gain_compress_en_o,
  output logic                               config_window_open_o
);

  import afcsp_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [NPIN-1:0] pins;
  logic [NPIN-1:0] lvl;
  logic [NPIN-1:0] rise;
  logic [NPIN-1:0] fall;

  assign pins = {preset_sel_i, config_serial_in_i, direct_port_read_en_n_i,
                 filtered_port_read_en_n_i, direct_port_clk_i, filtered_port_clk_i};

  for (genvar g = 0; g < NPIN; g++)
  begin : g_pin
    afcsp_sync #(
      .RST_VAL (PIN_RST[g])
    ) u_sync (
      .clk_i   (clk_i),
      .rstn_i  (rstn_i),
      .async_i (pins[g]),
      .level_o (lvl[g]),
      .rise_o  (rise[g]),
      .fall_o  (fall[g])
    );
  end

  logic a_en_rise;
  logic b_en_rise;
  logic pre;
  logic sdi;

  assign a_en_rise = rise[PIN_ACLK] && !lvl[PIN_RDA];
  assign b_en_rise = rise[PIN_BCLK] && !lvl[PIN_RDB];
  assign pre       = lvl[PIN_PRE];
  assign sdi       = lvl[PIN_SDI];

  // ---------------------------------------------------------------
  // conversion counting and data-ready
  // ---------------------------------------------------------------
  logic [CFG_W-1:0] act_cfg_q;
  logic [CFG_W-1:0] pend_cfg_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] factor;
  logic             is_avg;
  logic             drl_q;
  logic             drl_rise;
  logic             drl_fall;

  assign is_avg   = (act_cfg_q[FT_LSB +: CODE_W] == FT_AVG);
  assign factor   = CNT_ONE << act_cfg_q[DF_LSB +: CODE_W];
  assign cnt_nxt  = cnt_q + CNT_ONE;
  // averaging updates every conversion, so data-ready follows busy there
  assign drl_rise = conv_start_i && (is_avg || (cnt_q == '0));
  assign drl_fall = drl_q && conv_done_i;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      cnt_q <= '0;
    else if (sync_reset_i)
      cnt_q <= '0;
    else if (conv_start_i)
      cnt_q <= (is_avg || (cnt_nxt >= factor)) ? '0 : cnt_nxt;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      drl_q <= 1'b0;
    else if (drl_rise)
      drl_q <= 1'b1;
    else if (drl_fall)
      drl_q <= 1'b0;
  end

  // ---------------------------------------------------------------
  // transaction window and word assembly
  // ---------------------------------------------------------------
  afcsp_win_t       win_q;
  logic [3:0]       bit_cnt_q;
  logic [10:0]      shift_q;
  logic [11:0]      word;
  logic             open_evt;
  logic             sample;
  logic             word_done;
  logic             word_ok;
  logic             codes_ok;

  assign open_evt  = drl_fall || fall[PIN_RDA] || sync_reset_i;
  // preset mode ignores the serial word entirely
  assign sample    = (win_q == CFG_OPEN) && a_en_rise && !pre;
  assign word      = {shift_q, sdi};
  assign word_done = sample && (bit_cnt_q == BIT_LAST) && !drl_rise && !open_evt;
  assign codes_ok  = (word[FT_LSB +: CODE_W] >= FT_MIN) && (word[FT_LSB +: CODE_W] <= FT_AVG)
                  && (word[DF_LSB +: CODE_W] >= DF_MIN) && (word[DF_LSB +: CODE_W] <= DF_MAX);
  assign word_ok   = word_done && (word[11:10] == PFX_VALID) && codes_ok;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      win_q     <= CFG_OPEN;
      bit_cnt_q <= '0;
      shift_q   <= '0;
    end
    else if (open_evt)
    begin
      win_q     <= CFG_OPEN;
      bit_cnt_q <= '0;
    end
    else if (win_q == CFG_OPEN)
    begin
      if (drl_rise)
        win_q <= CFG_CLOSED;
      else if (sample)
      begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
        shift_q   <= {shift_q[9:0], sdi};
        if (bit_cnt_q == BIT_PFX && {shift_q[0], sdi} != PFX_VALID)
          win_q <= CFG_CLOSED;
        else if (bit_cnt_q == BIT_LAST)
          win_q <= CFG_CLOSED;
      end
    end
  end

  // ---------------------------------------------------------------
  // pending and active configuration
  // ---------------------------------------------------------------
  logic [CFG_W-1:0] preset_cfg;
  logic [CFG_W-1:0] pend_cfg_d;
  logic             pend_src;
  logic             filt_rst_q;

  assign preset_cfg = sdi ? CFG_PRESET_AVG : CFG_PRESET_SSINC;
  assign pend_src   = word_ok || pre;

  always_comb
  begin
    pend_cfg_d = pend_cfg_q;
    if (pre)
      pend_cfg_d = preset_cfg;
    else if (word_ok)
      pend_cfg_d = word[CFG_W-1:0];
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pend_cfg_q <= CFG_RESET;
      filt_rst_q <= 1'b0;
    end
    else
    begin
      pend_cfg_q <= pend_cfg_d;
      filt_rst_q <= (pend_cfg_d != pend_cfg_q);
    end
  end

  // new settings only take hold at a conversion boundary
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      act_cfg_q <= CFG_RESET;
    else if (conv_start_i)
      act_cfg_q <= pend_cfg_q;
  end

  // ---------------------------------------------------------------
  // port A filtered output frame
  // ---------------------------------------------------------------
  logic [FRAME_W-1:0] fshr_q;
  logic               fnext_bit;
  logic               foe_n_q;

  assign fnext_bit = fshr_q[FRAME_W-2];

  // the frame is only reloaded at data-ready fall, so a slow reader can
  // spread one result over many conversions
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      fshr_q <= '0;
    else if (drl_fall)
      fshr_q <= {filtered_result_i, act_cfg_q[DF_LSB +: CODE_W],
                 act_cfg_q[FT_LSB +: CODE_W]};
    else if (a_en_rise)
      fshr_q <= {fshr_q[FRAME_W-2:0], 1'b0};
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      foe_n_q <= 1'b1;
    else
      foe_n_q <= lvl[PIN_RDA];
  end

  // ---------------------------------------------------------------
  // port B no-latency output
  // ---------------------------------------------------------------
  logic                buf_valid;
  logic                buf_pop;
  logic [DIRECT_W-1:0] buf_data;
  logic [DIRECT_W-1:0] dshr_q;
  logic [5:0]          dbits_q;
  logic                doe_n_q;

  afcsp_buf2 #(
    .W     (DIRECT_W),
    .DEPTH (2)
  ) u_buf (
    .clk_i       (clk_i),
    .rstn_i      (rstn_i),
    .in_valid_i  (direct_valid_i),
    .in_ready_o  (direct_ready_o),
    .in_data_i   (direct_word_i),
    .out_valid_o (buf_valid),
    .out_ready_i (buf_pop),
    .out_data_o  (buf_data)
  );

  // a word leaves the buffer only once the previous one is fully shifted
  assign buf_pop = buf_valid && (dbits_q == '0);

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      dshr_q  <= '0;
      dbits_q <= '0;
    end
    else if (buf_pop)
    begin
      dshr_q  <= buf_data;
      dbits_q <= DIRECT_BITS;
    end
    else if (b_en_rise && dbits_q != '0)
    begin
      dshr_q  <= {dshr_q[DIRECT_W-2:0], 1'b0};
      dbits_q <= dbits_q - 6'h01;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      doe_n_q <= 1'b1;
    else
      doe_n_q <= lvl[PIN_RDB];
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign filtered_serial_out_o  = fshr_q[FRAME_W-1];
  assign filtered_serial_oe_n_o = foe_n_q;
  assign direct_serial_out_o    = dshr_q[DIRECT_W-1];
  assign direct_serial_oe_n_o   = doe_n_q;
  assign filtered_data_ready_o  = drl_q;
  assign filter_reset_o         = filt_rst_q;
  assign filter_type_o          = act_cfg_q[FT_LSB +: CODE_W];
  assign downsample_factor_o    = act_cfg_q[DF_LSB +: CODE_W];
  assign gain_expand_en_o       = act_cfg_q[GE_BIT];
  assign gain_compress_en_o     = act_cfg_q[GC_BIT];
  assign config_window_open_o   = (win_q == CFG_OPEN);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_win_twelve_close: assert property (sample && bit_cnt_q == 4'hB && !open_evt && !drl_rise
    |=> win_q == CFG_CLOSED) else $error("window still open after twelfth bit");
  a_prefix_reject: assert property (sample && bit_cnt_q == 4'h1 && !open_evt && !drl_rise
    && {shift_q[0], sdi} != 2'h2 |=> win_q == CFG_CLOSED) else $error("bad prefix kept window");
  a_drl_closes_win: assert property (win_q == CFG_OPEN && drl_rise && !open_evt
    |=> win_q == CFG_CLOSED) else $error("data-ready rise did not close window");
  a_open_restarts: assert property (open_evt
    |=> win_q == CFG_OPEN && bit_cnt_q == 4'h0) else $error("window open did not restart");
  a_pend_valid_only: assert property ($changed(pend_cfg_q)
    |-> $past(pend_src)) else $error("configuration changed without a valid word");
  a_word_applied: assert property (word_ok && !pre
    |=> pend_cfg_q == $past(word[9:0])
        && filter_reset_o == ($past(word[9:0]) != $past(pend_cfg_q)))
    else $error("valid word not taken");
  a_act_next_conv: assert property (conv_start_i
    |=> act_cfg_q == $past(pend_cfg_q)) else $error("setting not applied at conversion");
  a_preset_pick: assert property (pre
    |=> pend_cfg_q == $past(preset_cfg)) else $error("preset configuration not selected");
  a_drl_span: assert property (filtered_data_ready_o && !conv_done_i
    |=> filtered_data_ready_o) else $error("data-ready dropped early");
  a_drl_bound: assert property (filtered_data_ready_o && conv_done_i && !conv_start_i
    |=> !filtered_data_ready_o) else $error("data-ready did not fall at completion");
  a_frame_shift: assert property (a_en_rise && !drl_fall
    |=> filtered_serial_out_o == $past(fnext_bit)) else $error("filtered bit did not advance");
  a_oe_follows: assert property (lvl[PIN_RDA] ##1 lvl[PIN_RDA]
    |-> filtered_serial_oe_n_o) else $error("port A driven while disabled");

endmodule : afcsp_serial_port

// [verification/afcsp_host_model.sv]
// Purpose: host model driving both serial ports of the converter block
// Assumes: serial clocks idle low, 80 ns period, lines move on clk_i falls
// Notes:   tasks are called by the bench between conversions only
`timescale 1ns/1ps
module afcsp_host_model (
  input  wire logic clk_i,
  input  wire logic a_out_i,
  input  wire logic b_out_i,
  output logic      a_clk_o,
  output logic      b_clk_o,
  output logic      a_en_n_o,
  output logic      b_en_n_o,
  output logic      sdi_o
);
  // ----------------------------------------------------------
  // serial transfers
  // ----------------------------------------------------------
  // sdi idles low so stray reads only give ignored zero words
  initial {a_clk_o, b_clk_o, a_en_n_o, b_en_n_o, sdi_o} = 5'h06;

  task automatic half();
    repeat (10) @(negedge clk_i);
  endtask : half

  task automatic tick_a(input logic d, output logic q);
    sdi_o = d;
    half();
    q = a_out_i;
    a_clk_o = 1'b1;
    half();
    a_clk_o = 1'b0;
  endtask : tick_a

  task automatic write_cfg(input logic [11:0] w);
    logic q;
    a_en_n_o = 1'b0;
    half();
    for (int i = 11; i >= 0; i--)
      tick_a(w[i], q);
    sdi_o = 1'b0;
    a_en_n_o = 1'b1;
    half();
  endtask : write_cfg

  // enable drop also opens a window; zero sdi makes it a dropped word
  task automatic read_a(input int n, inout logic [39:0] v);
    logic q;
    a_en_n_o = 1'b0;
    half();
    repeat (n)
    begin
      tick_a(1'b0, q);
      v = {v[38:0], q};
    end
    a_en_n_o = 1'b1;
    half();
  endtask : read_a

  task automatic read_b(output logic [31:0] v);
    b_en_n_o = 1'b0;
    half();
    repeat (32)
    begin
      v = {v[30:0], b_out_i};
      b_clk_o = 1'b1;
      half();
      b_clk_o = 1'b0;
      half();
    end
    b_en_n_o = 1'b1;
    half();
  endtask : read_b
endmodule : afcsp_host_model

// [verification/tb_adc_filter_config_serial_port.sv]
// Purpose: self-checking bench of the filter configuration serial port
// Assumes: host model drives the serial pins; bench plays the converter core
// Notes:   conversions are short; the host stays quiet while one runs
`timescale 1ns/1ps
module tb_adc_filter_config_serial_port;
  import afcsp_pkg::*;
  logic        clk_i = 1'b0;
  logic        rstn_i, preset_sel_i, conv_start_i, conv_done_i, sync_reset_i;
  logic        a_clk, b_clk, a_en_n, b_en_n, sdi, a_out, a_oe_n, b_out, b_oe_n;
  logic        dready, frst, ge, gc, win_open, direct_ready, direct_valid_i, dr, acc;
  logic [31:0] filtered_result_i, direct_word_i, wv;
  logic [3:0]  ft, df;
  logic [9:0]  cfg_now, exp;
  logic [39:0] frame;
  logic [4:0]  drs;
  logic [11:0] bad_w [7] = '{12'hC35, 12'h4A5, 12'h860, 12'h878, 12'h815, 12'h8F5, 12'h000};
  int          bad_count = 0, samples_checked = 0, fr_count = 0, n = 0;

  assign cfg_now = {gc, ge, df, ft};
  always #2 clk_i = ~clk_i;
  always @(negedge clk_i) if (frst === 1'b1) fr_count <= fr_count + 1;

  afcsp_serial_port i_dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .filtered_port_clk_i(a_clk),
    .direct_port_clk_i(b_clk), .filtered_port_read_en_n_i(a_en_n),
    .direct_port_read_en_n_i(b_en_n), .config_serial_in_i(sdi),
    .preset_sel_i(preset_sel_i), .conv_start_i(conv_start_i), .conv_done_i(conv_done_i),
    .sync_reset_i(sync_reset_i), .filtered_result_i(filtered_result_i),
    .direct_word_i(direct_word_i), .direct_valid_i(direct_valid_i),
    .direct_ready_o(direct_ready), .filtered_serial_out_o(a_out),
    .filtered_serial_oe_n_o(a_oe_n), .direct_serial_out_o(b_out),
    .direct_serial_oe_n_o(b_oe_n), .filtered_data_ready_o(dready), .filter_reset_o(frst),
    .filter_type_o(ft), .downsample_factor_o(df), .gain_expand_en_o(ge),
    .gain_compress_en_o(gc), .config_window_open_o(win_open));

  afcsp_host_model i_host (
    .clk_i(clk_i), .a_out_i(a_out), .b_out_i(b_out), .a_clk_o(a_clk), .b_clk_o(b_clk),
    .a_en_n_o(a_en_n), .b_en_n_o(b_en_n), .sdi_o(sdi));

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask : chk

  task automatic conv(input logic [31:0] res, output logic r);
    conv_start_i = 1'b1;
    @(negedge clk_i);
    conv_start_i = 1'b0;
    @(negedge clk_i);
    r = dready;
    repeat (3) @(negedge clk_i);
    filtered_result_i = res;
    conv_done_i = 1'b1;
    @(negedge clk_i);
    conv_done_i = 1'b0;
    repeat (6) @(negedge clk_i);
    chk("data ready low", 1'b0, dready);
  endtask : conv

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  // hang guard, far above the expected run length
  initial
  begin
    #200000;
    bad_count++;
    tally_and_finish();
  end

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial
  begin
    {rstn_i, preset_sel_i, conv_start_i, conv_done_i, sync_reset_i, direct_valid_i} = 6'h00;
    filtered_result_i = 32'h0;
    direct_word_i = 32'h0;
    repeat (20) @(negedge clk_i);
    rstn_i = 1'b1;
    repeat (6) @(negedge clk_i);
    chk("config", CFG_RESET, cfg_now);
    chk("window", 1'b1, win_open);
    chk("oe_n", 2'h3, {a_oe_n, b_oe_n});
    i_host.write_cfg(12'h825);
    chk("window", 1'b0, win_open);
    chk("config", CFG_RESET, cfg_now);
    chk("filter resets", 1, fr_count);
    conv(32'h0, dr);
    chk("config", 10'h025, cfg_now);
    for (int k = 0; k < 13; k++)
    begin
      exp = {k[1], k[0], 4'(k + 2), 4'(k % 7 + 1)};
      i_host.write_cfg({2'h2, exp});
      conv(32'h0, dr);
      chk("config", exp, cfg_now);
    end
    chk("filter resets", 14, fr_count);
    i_host.write_cfg(12'h825);
    conv(32'h0, dr);
    foreach (bad_w[j])
    begin
      i_host.write_cfg(bad_w[j]);
      conv(32'h0, dr);
      chk("config", 10'h025, cfg_now);
    end
    chk("filter resets", 15, fr_count);
    // factor 4 from here: one update every fourth conversion
    sync_reset_i = 1'b1;
    @(negedge clk_i);
    sync_reset_i = 1'b0;
    repeat (4) @(negedge clk_i);
    conv(32'hA5C3_0F96, dr);
    drs[0] = dr;
    chk("window", 1'b1, win_open);
    frame = 40'h0;
    fork
      i_host.read_a(20, frame);
      begin
        repeat (20) @(negedge clk_i);
        chk("oe_n a", 1'b0, a_oe_n);
      end
    join
    conv(32'h1234_5678, dr);
    drs[1] = dr;
    i_host.read_a(20, frame);
    chk("frame", {32'hA5C3_0F96, 8'h25}, frame);
    for (int k = 2; k < 5; k++)
    begin
      conv(32'h0, dr);
      drs[k] = dr;
    end
    chk("ready pattern", 5'h11, drs);
    preset_sel_i = 1'b1;
    i_host.sdi_o = 1'b1;
    repeat (8) @(negedge clk_i);
    conv(32'h0, dr);
    chk("config", CFG_PRESET_AVG, cfg_now);
    i_host.write_cfg(12'h825);
    conv(32'h0, dr);
    chk("config", CFG_PRESET_SSINC, cfg_now);
    preset_sel_i = 1'b0;
    // port B: source keeps offering while the host is not reading
    direct_valid_i = 1'b1;
    for (int k = 0; k < 8; k++)
    begin
      direct_word_i = 32'h5A00_0000 + n;
      acc = direct_ready;
      @(negedge clk_i);
      n += int'(acc);
    end
    direct_valid_i = 1'b0;
    chk("words taken", 3, n);
    for (int k = 0; k < 3; k++)
    begin
      fork
        i_host.read_b(wv);
        begin
          repeat (20) @(negedge clk_i);
          chk("oe_n b", 1'b0, b_oe_n);
        end
      join
      chk("direct word", 32'h5A00_0000 + k, wv);
    end
    chk("direct ready", 1'b1, direct_ready);
    tally_and_finish();
  end
endmodule : tb_adc_filter_config_serial_port
